// [rtl/pck_top.sv]
// plane colour-key match with double-buffered plane registers
module pck_top #(
	parameter int                   PIX_W = 10
) (
	input  wire logic               ref_clk_i,
	input  wire logic               rst_n_i,
	input  wire logic               mmio_wr_i,
	input  wire logic               mmio_rd_i,
	input  wire logic [19:0]        mmio_addr_i,
	input  wire logic [31:0]        mmio_wdata_i,
	output logic      [31:0]        mmio_rdata_o,
	output logic                    mmio_rvalid_o,
	input  wire logic               plane_en_i,
	input  wire logic               pipe_en_i,
	input  wire logic               vblank_start_i,
	input  wire logic               left_vblank_i,
	input  wire logic               right_vblank_i,
	input  wire logic               eye_sel_right_i,
	input  wire logic               src_yuv_i,
	input  wire logic               pix_valid_i,
	input  wire logic [PIX_W-1:0]   pix_r_i,
	input  wire logic [PIX_W-1:0]   pix_g_i,
	input  wire logic [PIX_W-1:0]   pix_b_i,
	input  wire logic               pix_ext_i,
	output logic                    key_valid_o,
	output logic                    key_match_o,
	output logic      [31:0]        act_key_val_o,
	output logic      [31:0]        act_key_msk_o,
	output logic      [31:0]        act_key_max_o,
	output logic      [31:0]        act_pan_ofs_o,
	output logic      [31:0]        act_pf_ofs_o,
	output logic      [31:0]        act_left_surf_o,
	output logic                    armed_o
);

	localparam int NREG = pck_pkg::NREG;
	localparam int NDB  = pck_pkg::RI_SURF;
	localparam int KW   = pck_pkg::KEY_W;

	if (PIX_W < KW) begin : g_bad_width
		$error("pixel width below key field width");
	end

	// ---------------- reset release ----------------
	logic rst_s1_q;
	logic rst_s2_q;
	logic rst_n;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	assign rst_n = rst_s2_q;

	// ---------------- address decode ----------------
	logic [NREG-1:0] hit;
	logic [NREG-1:0] wr_sel;
	logic            any_hit;
	logic [31:0]     wdata_m [NREG];

	for (genvar i = 0; i < NREG; i++) begin : g_dec
		assign hit[i] = mmio_addr_i == pck_pkg::REG_OFS[i];
		assign wr_sel[i] = mmio_wr_i & hit[i];
		// reserved and must_be_zero bits are never stored
		assign wdata_m[i] = mmio_wdata_i & pck_pkg::REG_WMASK[i];
	end

	assign any_hit = |hit;

	// ---------------- arm and update points ----------------
	logic surf_wr;
	logic arm;
	logic upd_main;
	logic upd_left;
	logic eye_vblank;

	assign surf_wr = wr_sel[pck_pkg::RI_SURF];
	// a disabled plane keeps every double-buffered register armed
	assign arm = surf_wr | ~plane_en_i;
	assign upd_main = vblank_start_i | ~pipe_en_i | ~plane_en_i;
	assign eye_vblank = eye_sel_right_i ? right_vblank_i : left_vblank_i;
	assign upd_left = eye_vblank | ~pipe_en_i | ~plane_en_i;

	// ---------------- double-buffered registers ----------------
	logic [31:0]    pend [NREG];
	logic [31:0]    act  [NDB];
	logic [NDB-1:0] armed;

	for (genvar i = 0; i < NDB; i++) begin : g_db
		logic upd;

		assign upd = (i == pck_pkg::RI_LEFT) ? upd_left : upd_main;

		pck_dbuf #(
			.W         (32),
			.RST       (pck_pkg::RST_REG)
		) u_dbuf (
			.ref_clk_i (ref_clk_i),
			.rst_n_i   (rst_n),
			.wr_i      (wr_sel[i]),
			.wdata_i   (wdata_m[i]),
			.arm_i     (arm),
			.upd_i     (upd),
			.pend_o    (pend[i]),
			.act_o     (act[i]),
			.armed_o   (armed[i])
		);
	end

	// surface base itself is single buffered here; its write is the trigger
	logic [31:0] surf_q;
	logic [31:0] surf_d;

	assign surf_d = surf_wr ? wdata_m[pck_pkg::RI_SURF] : surf_q;

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			surf_q <= pck_pkg::RST_REG;
		end else begin
			surf_q <= surf_d;
		end
	end

	assign pend[pck_pkg::RI_SURF] = surf_q;

	// ---------------- register read ----------------
	logic [31:0] rd_val;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic        rvalid_q;

	always_comb begin
		rd_val = 32'h0000_0000;
		for (int i = 0; i < NREG; i++) begin
			if (hit[i]) begin
				rd_val = pend[i];
			end
		end
	end

	// unmapped reads answer zero
	assign rdata_d = (mmio_rd_i & any_hit) ? rd_val : 32'h0000_0000;

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q  <= 32'h0000_0000;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= mmio_rd_i;
		end
	end

	// ---------------- key compare ----------------
	localparam int NCH_L = pck_pkg::NCH;

	logic [PIX_W-1:0] pix_ch [NCH_L];
	logic [NCH_L-1:0] ch_pass;
	logic [31:0]      kval;
	logic [31:0]      kmsk;
	logic [31:0]      kmax;
	logic             range_ok;
	logic             match;

	// channel 0 is U/blue, 1 is Y/green, 2 is V/red
	assign pix_ch[0] = pix_b_i;
	assign pix_ch[1] = pix_g_i;
	assign pix_ch[2] = pix_r_i;

	assign kval = act[pck_pkg::RI_KEYVAL];
	assign kmsk = act[pck_pkg::RI_KEYMSK];
	assign kmax = act[pck_pkg::RI_KEYMAX];

	for (genvar c = 0; c < NCH_L; c++) begin : g_ch
		localparam int FL = pck_pkg::KEY_FLD_LSB + c * KW;

		pck_chan_cmp #(
			.PIX_W  (PIX_W)
		) u_cmp (
			.pix_i  (pix_ch[c]),
			.key_i  (kval[FL +: KW]),
			.max_i  (kmax[FL +: KW]),
			.mask_i (kmsk[FL +: KW]),
			.en_i   (kmsk[pck_pkg::CH_EN_LSB + c]),
			.yuv_i  (src_yuv_i),
			.pass_o (ch_pass[c])
		);
	end

	// out-of-range RGB input is refused before the channel result
	assign range_ok = src_yuv_i | ~pix_ext_i;
	assign match = (&ch_pass) & range_ok;

	logic key_valid_q;
	logic key_match_q;

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			key_valid_q <= 1'b0;
			key_match_q <= 1'b0;
		end else begin
			key_valid_q <= pix_valid_i;
			key_match_q <= pix_valid_i & match;
		end
	end

	// ---------------- outputs ----------------
	assign mmio_rdata_o    = rdata_q;
	assign mmio_rvalid_o   = rvalid_q;
	assign key_valid_o     = key_valid_q;
	assign key_match_o     = key_match_q;
	assign act_key_val_o   = act[pck_pkg::RI_KEYVAL];
	assign act_key_msk_o   = act[pck_pkg::RI_KEYMSK];
	assign act_key_max_o   = act[pck_pkg::RI_KEYMAX];
	assign act_pan_ofs_o   = act[pck_pkg::RI_PANOFS];
	assign act_pf_ofs_o    = act[pck_pkg::RI_PFOFS];
	assign act_left_surf_o = act[pck_pkg::RI_LEFT];
	// key value armed flag; the other double-buffered flags arm with it, but the left surface flag clears at eye vblank
	assign armed_o         = armed[pck_pkg::RI_KEYVAL];

endmodule

// [common/pck_pkg.sv]
// constants for the plane colour-key match block
// What this block does
// - bit 24 enables the U/blue channel
// - RGB 8-bit masks; zero bit ignores pixel bit
// - YUV uses key value as channel minimums
// - key value fields V/R, Y/G, U/B
// - RGB compares exact key under masks
// - extended-range RGB pixels never match
// - wide components compare by their MSBs
// - surface write or plane off arms pending
// - armed key/offset apply at vblank or idle
// - left surface applies at chosen eye vblank
// - left surface address 31:12, low bits zero
// - YUV maximums come from upper-bound register
package pck_pkg;

	localparam int ADDR_W = 20;
	localparam int DATA_W = 32;
	localparam int KEY_W  = 8;
	localparam int NCH    = 3;
	localparam int NREG   = 7;

	// register indices inside the map
	localparam int RI_KEYVAL = 0;
	localparam int RI_KEYMSK = 1;
	localparam int RI_KEYMAX = 2;
	localparam int RI_PANOFS = 3;
	localparam int RI_PFOFS  = 4;
	localparam int RI_LEFT   = 5;
	localparam int RI_SURF   = 6;

	localparam logic [ADDR_W-1:0] OFS_KEY_COMPARE_VALUE = 20'h70194;
	localparam logic [ADDR_W-1:0] OFS_KEY_CHANNEL_MASK  = 20'h70198;
	localparam logic [ADDR_W-1:0] OFS_KEY_UPPER_BOUND   = 20'h701A0;
	localparam logic [ADDR_W-1:0] OFS_PAN_OFFSET        = 20'h701A4;
	localparam logic [ADDR_W-1:0] OFS_PF_PAN_OFFSET     = 20'h7089C;
	localparam logic [ADDR_W-1:0] OFS_LEFT_SURF_BASE    = 20'h701B0;
	localparam logic [ADDR_W-1:0] OFS_SURFACE_BASE      = 20'h701BC;

	localparam logic [ADDR_W-1:0] REG_OFS [NREG] = '{
		OFS_KEY_COMPARE_VALUE,
		OFS_KEY_CHANNEL_MASK,
		OFS_KEY_UPPER_BOUND,
		OFS_PAN_OFFSET,
		OFS_PF_PAN_OFFSET,
		OFS_LEFT_SURF_BASE,
		OFS_SURFACE_BASE
	};

	// writable bits; the rest read as zero
	localparam logic [DATA_W-1:0] WMASK_KEYVAL = 32'h00FF_FFFF;
	localparam logic [DATA_W-1:0] WMASK_KEYMSK = 32'h87FF_FFFF;
	localparam logic [DATA_W-1:0] WMASK_KEYMAX = 32'hFFFF_FFFF;
	localparam logic [DATA_W-1:0] WMASK_PANOFS = 32'hFFFF_FFFF;
	localparam logic [DATA_W-1:0] WMASK_LEFT   = 32'hFFFF_F000;
	localparam logic [DATA_W-1:0] WMASK_SURF   = 32'hFFFF_F000;

	localparam logic [DATA_W-1:0] REG_WMASK [NREG] = '{
		WMASK_KEYVAL,
		WMASK_KEYMSK,
		WMASK_KEYMAX,
		WMASK_PANOFS,
		WMASK_PANOFS,
		WMASK_LEFT,
		WMASK_SURF
	};

	localparam logic [DATA_W-1:0] RST_REG = 32'h0000_0000;

	// field positions
	localparam int KEY_FLD_LSB = 0;
	localparam int CH_EN_LSB   = 24;
	localparam int ALPHA_EN    = 31;
	localparam int LEFT_LSB    = 12;

endpackage

// [rtl/pck_dbuf.sv]
// double-buffered register: pending, armed flag and active copy
module pck_dbuf #(
	parameter int                 W   = 32,
	parameter logic [W-1:0]       RST = '0
) (
	input  wire logic             ref_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             wr_i,
	input  wire logic [W-1:0]     wdata_i,
	input  wire logic             arm_i,
	input  wire logic             upd_i,
	output logic      [W-1:0]     pend_o,
	output logic      [W-1:0]     act_o,
	output logic                  armed_o
);

	logic [W-1:0] pend_q;
	logic [W-1:0] pend_d;
	logic [W-1:0] act_q;
	logic [W-1:0] act_d;
	logic         armed_q;
	logic         armed_d;

	assign pend_d = wr_i ? wdata_i : pend_q;
	// a new arm in the update cycle survives, so no arm is lost
	assign armed_d = arm_i | (armed_q & ~upd_i);
	assign act_d = (armed_q & upd_i) ? pend_q : act_q;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_q  <= RST;
			act_q   <= RST;
			armed_q <= 1'b0;
		end else begin
			pend_q  <= pend_d;
			act_q   <= act_d;
			armed_q <= armed_d;
		end
	end

	assign pend_o  = pend_q;
	assign act_o   = act_q;
	assign armed_o = armed_q;

endmodule

// [rtl/pck_chan_cmp.sv]
// one colour channel of the key compare
module pck_chan_cmp #(
	parameter int                 PIX_W = 10
) (
	input  wire logic [PIX_W-1:0] pix_i,
	input  wire logic [7:0]       key_i,
	input  wire logic [7:0]       max_i,
	input  wire logic [7:0]       mask_i,
	input  wire logic             en_i,
	input  wire logic             yuv_i,
	output logic                  pass_o
);

	logic [7:0] msb;
	logic       rgb_hit;
	logic       yuv_hit;

	// only the top bits of a wide component are looked at
	assign msb = pix_i[PIX_W-1 -: 8];
	assign rgb_hit = ((msb ^ key_i) & mask_i) == 8'h00;
	assign yuv_hit = (msb >= key_i) && (msb <= max_i);
	// a disabled channel never blocks a match
	assign pass_o = ~en_i | (yuv_i ? yuv_hit : rgb_hit);

endmodule

// [test/pck_checker.sv]
// assertions on the ports of the plane colour-key match block
module pck_checker #(
	parameter int PIX_W = 10
) (
	input wire logic             ref_clk_i,
	input wire logic             rst_n_i,
	input wire logic             mmio_wr_i,
	input wire logic [19:0]      mmio_addr_i,
	input wire logic             plane_en_i,
	input wire logic             pipe_en_i,
	input wire logic             vblank_start_i,
	input wire logic             left_vblank_i,
	input wire logic             right_vblank_i,
	input wire logic             eye_sel_right_i,
	input wire logic             src_yuv_i,
	input wire logic             pix_valid_i,
	input wire logic [PIX_W-1:0] pix_g_i,
	input wire logic [PIX_W-1:0] pix_b_i,
	input wire logic             pix_ext_i,
	input wire logic             key_valid_o,
	input wire logic             key_match_o,
	input wire logic [31:0]      act_key_val_o,
	input wire logic [31:0]      act_key_msk_o,
	input wire logic [31:0]      act_key_max_o,
	input wire logic [31:0]      act_left_surf_o,
	input wire logic             armed_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic [7:0] pb = pix_b_i[PIX_W-1 -: 8];
	wire logic [7:0] pg = pix_g_i[PIX_W-1 -: 8];
	wire logic [2:0] en = act_key_msk_o[26:24];
	wire logic rgb_ok = pix_valid_i && !src_yuv_i && !pix_ext_i;
	wire logic b_hit = ((pb ^ act_key_val_o[7:0]) & act_key_msk_o[7:0]) == 8'h00;
	wire logic g_hit = act_key_val_o[15:8] <= pg && pg <= act_key_max_o[15:8];
	wire logic upd = vblank_start_i || !pipe_en_i || !plane_en_i;
	wire logic eye = eye_sel_right_i ? right_vblank_i : left_vblank_i;
	a_blue_key_cmp: assert property (
		rgb_ok && en == 3'h1 |=> key_match_o == $past(b_hit))
		else $error("blue masked compare wrong");
	a_green_yuv_range: assert property (
		pix_valid_i && src_yuv_i && en == 3'h2 |=> key_match_o == $past(g_hit))
		else $error("green range test wrong");
	a_ext_no_match: assert property (
		pix_valid_i && !src_yuv_i && pix_ext_i |=> !key_match_o)
		else $error("extended pixel matched");
	a_none_enabled: assert property (
		rgb_ok && en == 3'h0 |=> key_valid_o && key_match_o)
		else $error("no channel enabled but no match");
	a_keyval_rsvd: assert property (
		act_key_val_o[31:24] == 8'h00)
		else $error("key value top byte not zero");
	a_left_low_zero: assert property (
		act_left_surf_o[11:0] == 12'h000)
		else $error("left surface low bits not zero");
	a_key_update: assert property (
		!$stable(act_key_val_o) |-> $past(upd && armed_o))
		else $error("key value changed outside update");
	a_left_update: assert property (
		!$stable(act_left_surf_o) |-> $past(eye || !pipe_en_i || !plane_en_i))
		else $error("left surface changed outside update");
	a_arm_cause: assert property (
		$rose(armed_o) |-> $past(!plane_en_i || mmio_wr_i
			&& mmio_addr_i == pck_pkg::OFS_SURFACE_BASE))
		else $error("armed without cause");
	c_match: cover property (key_valid_o && key_match_o);
	c_arm: cover property ($rose(armed_o));
	c_left: cover property (!$stable(act_left_surf_o));
endmodule

bind pck_top pck_checker #(.PIX_W(PIX_W)) chk_i (.*);

// [test/tb.sv]
// self-checking bench for the plane colour-key match block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [19:0] KV = pck_pkg::OFS_KEY_COMPARE_VALUE;
	localparam logic [19:0] KM = pck_pkg::OFS_KEY_CHANNEL_MASK;
	localparam logic [19:0] KX = pck_pkg::OFS_KEY_UPPER_BOUND;
	localparam logic [19:0] SB = pck_pkg::OFS_SURFACE_BASE;
	logic ref_clk_i, rst_n_i, mmio_wr_i, mmio_rd_i, plane_en_i, pipe_en_i;
	logic vblank_start_i, left_vblank_i, right_vblank_i, eye_sel_right_i;
	logic src_yuv_i, pix_valid_i, pix_ext_i, mmio_rvalid_o, key_valid_o;
	logic key_match_o, armed_o;
	logic [19:0] mmio_addr_i;
	logic [31:0] mmio_wdata_i, mmio_rdata_o, act_key_val_o, act_key_msk_o;
	logic [31:0] act_key_max_o, act_pan_ofs_o, act_pf_ofs_o, act_left_surf_o;
	logic [9:0]  pix_r_i, pix_g_i, pix_b_i;
	int          mismatches, n_compared, cycles;

	pck_top #(.PIX_W(10)) uut (.*);

	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	task wr(input logic [19:0] a, input logic [31:0] d);
		@(negedge ref_clk_i);
		mmio_wr_i = 1'b1;
		mmio_addr_i = a;
		mmio_wdata_i = d;
		@(negedge ref_clk_i);
		mmio_wr_i = 1'b0;
	endtask
	task rd(input logic [19:0] a, input logic [31:0] e);
		@(negedge ref_clk_i);
		mmio_rd_i = 1'b1;
		mmio_addr_i = a;
		@(negedge ref_clk_i);
		mmio_rd_i = 1'b0;
		chk(32'(mmio_rvalid_o), 32'h1);
		chk(mmio_rdata_o, e);
	endtask
	// one-cycle pulse on {frame vblank, left eye, right eye}
	task vb(input logic [2:0] s);
		@(negedge ref_clk_i);
		{vblank_start_i, left_vblank_i, right_vblank_i} = s;
		@(negedge ref_clk_i);
		{vblank_start_i, left_vblank_i, right_vblank_i} = 3'h0;
	endtask
	task px(input logic y, x, input logic [7:0] r, g, b, input logic e);
		@(negedge ref_clk_i);
		pix_valid_i = 1'b1;
		src_yuv_i = y;
		pix_ext_i = x;
		// low bits set so only the top byte may decide
		pix_r_i = {r, 2'h3};
		pix_g_i = {g, 2'h3};
		pix_b_i = {b, 2'h3};
		@(negedge ref_clk_i);
		pix_valid_i = 1'b0;
		chk(32'(key_valid_o), 32'h1);
		chk(32'(key_match_o), 32'(e));
	endtask
	// plane off makes new key values active at once
	task cfg(input logic [31:0] m, v, x);
		plane_en_i = 1'b0;
		wr(KM, m);
		wr(KV, v);
		wr(KX, x);
		cyc(1);
		plane_en_i = 1'b1;
	endtask

	task t_regs;
		for (int i = 0; i < pck_pkg::NREG; i++) begin
			rd(pck_pkg::REG_OFS[i], 32'h0);
			wr(pck_pkg::REG_OFS[i], 32'hFFFF_FFFF);
			rd(pck_pkg::REG_OFS[i], pck_pkg::REG_WMASK[i]);
		end
		wr(20'h70190, 32'hFFFF_FFFF);
		rd(20'h70190, 32'h0);
		$display("test regs done");
	endtask
	task t_dbuf;
		chk(act_key_val_o, 32'h0);
		vb(3'h4);
		chk(act_key_val_o, 32'h00FF_FFFF);
		chk(act_key_msk_o, pck_pkg::WMASK_KEYMSK);
		chk(act_key_max_o, pck_pkg::WMASK_KEYMAX);
		chk(act_pf_ofs_o, pck_pkg::WMASK_PANOFS);
		chk(act_left_surf_o, 32'h0);
		wr(KV, 32'h0012_3456);
		vb(3'h4);
		chk(act_key_val_o, 32'h00FF_FFFF);
		eye_sel_right_i = 1'b1; // right eye vblank selected first
		vb(3'h2);
		chk(act_left_surf_o, 32'h0);
		vb(3'h1);
		chk(act_left_surf_o, 32'hFFFF_F000);
		wr(SB, 32'h0);
		chk(act_key_val_o, 32'h00FF_FFFF);
		vb(3'h4);
		chk(act_key_val_o, 32'h0012_3456);
		plane_en_i = 1'b0;
		wr(pck_pkg::OFS_PAN_OFFSET, 32'h0ABC_0123);
		cyc(1);
		chk(act_pan_ofs_o, 32'h0ABC_0123);
		plane_en_i = 1'b1;
		// pipe off is an update point of its own
		wr(KV, 32'h0065_4321);
		wr(pck_pkg::OFS_LEFT_SURF_BASE, 32'h0012_3FFF);
		wr(SB, 32'h0);
		chk(32'(armed_o), 32'h1);
		pipe_en_i = 1'b0;
		cyc(1);
		chk(act_key_val_o, 32'h0065_4321);
		chk(act_left_surf_o, 32'h0012_3000);
		pipe_en_i = 1'b1;
		// left eye vblank selected this time
		wr(pck_pkg::OFS_LEFT_SURF_BASE, 32'h0045_6000);
		wr(SB, 32'h0);
		eye_sel_right_i = 1'b0;
		vb(3'h1);
		chk(act_left_surf_o, 32'h0012_3000);
		vb(3'h2);
		chk(act_left_surf_o, 32'h0045_6000);
		$display("test double buffer done");
	endtask
	task t_pix;
		cfg(32'h0100_00F0, 32'h0011_2250, 32'h0);
		px(1'b0, 1'b0, 8'h11, 8'h22, 8'h5F, 1'b1);
		px(1'b0, 1'b0, 8'h00, 8'h00, 8'h6F, 1'b0);
		px(1'b0, 1'b1, 8'h11, 8'h22, 8'h5F, 1'b0);
		cfg(32'h0000_00F0, 32'h0000_0050, 32'h0);
		px(1'b0, 1'b0, 8'h00, 8'h00, 8'h6F, 1'b1);
		cfg(32'h0200_0000, 32'h0000_2000, 32'h0000_4000);
		px(1'b1, 1'b0, 8'h00, 8'h40, 8'h00, 1'b1);
		px(1'b1, 1'b0, 8'h00, 8'h41, 8'h00, 1'b0);
		px(1'b1, 1'b0, 8'h00, 8'h1F, 8'h00, 1'b0);
		px(1'b1, 1'b1, 8'h00, 8'h20, 8'h00, 1'b1);
		$display("test pixel compare done");
	endtask

	task end_of_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// a hang costs a mismatch and ends the run
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			end_of_test;
		end
	end

	initial begin
		{rst_n_i, mmio_wr_i, mmio_rd_i, vblank_start_i} = 4'h0;
		{left_vblank_i, right_vblank_i, eye_sel_right_i} = 3'h0;
		{src_yuv_i, pix_valid_i, pix_ext_i} = 3'h0;
		{plane_en_i, pipe_en_i} = 2'h3;
		mmio_addr_i = 20'h0;
		mmio_wdata_i = 32'h0;
		{pix_r_i, pix_g_i, pix_b_i} = 30'h0;
		repeat (8) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		rst_n_i = 1'b1;
		cyc(3);
		t_regs;
		t_dbuf;
		t_pix;
		end_of_test;
	end
endmodule
